// ### include/ctu_pkg.sv
// charge time unit edge control: shared offsets, fields, resets, types
// assumes a 32-bit AHB-Lite slave with one register per aligned word

package ctu_pkg;

    // ************************************************************
    // register map
    // ************************************************************
    localparam int CTU_ADDR_W = 12;
    localparam logic [11:0] CTU_OFS_TIMING = 12'h000;
    localparam logic [11:0] CTU_OFS_SOURCE = 12'h004;
    localparam logic [11:0] CTU_OFS_DISCH = 12'h008;

    localparam logic [15:0] CTU_RST_TIMING = 16'h0000;
    localparam logic [15:0] CTU_RST_SOURCE = 16'h0000;
    localparam logic [15:0] CTU_RST_DISCH = 16'h0000;

    // writable bits; the rest read as zero
    localparam logic [15:0] CTU_MSK_TIMING = 16'hbfff;
    localparam logic [15:0] CTU_MSK_SOURCE = 16'hfffd;
    localparam logic [15:0] CTU_MSK_DISCH = 16'h0017;

    // ************************************************************
    // field positions
    // ************************************************************
    localparam int CTU_B_UNIT_EN = 15;
    localparam int CTU_B_SIDL = 13;
    localparam int CTU_B_DGEN = 12;
    localparam int CTU_B_EPASS = 11;
    localparam int CTU_B_ORDER = 10;
    localparam int CTU_B_DISCH = 9;
    localparam int CTU_B_TRIG = 8;
    localparam int CTU_B_TRIM = 2;
    localparam int CTU_B_RANGE = 0;

    localparam int CTU_B_E1_SENS = 15;
    localparam int CTU_B_E1_POL = 14;
    localparam int CTU_B_E1_SRC = 10;
    localparam int CTU_B_SEEN2 = 9;
    localparam int CTU_B_SEEN1 = 8;
    localparam int CTU_B_E2_SENS = 7;
    localparam int CTU_B_E2_POL = 6;
    localparam int CTU_B_E2_SRC = 2;
    localparam int CTU_B_HIGH_RNG = 0;

    localparam int CTU_B_RST_EN = 4;
    localparam int CTU_B_DSRC = 0;

    // ************************************************************
    // source codes
    // ************************************************************
    localparam logic [3:0] CTU_SRC_TIMER1 = 4'h0;
    localparam logic [3:0] CTU_SRC_OC1 = 4'h1;
    localparam logic [3:0] CTU_SRC_PIN2 = 4'h2;
    localparam logic [3:0] CTU_SRC_PIN1 = 4'h3;
    localparam logic [3:0] CTU_E1_PIN_LO = 4'h4;
    localparam logic [3:0] CTU_E1_PIN_HI = 4'h9;
    localparam logic [3:0] CTU_E1_CAP_LO = 4'ha;
    localparam logic [3:0] CTU_E1_CAP_HI = 4'hc;
    localparam logic [3:0] CTU_SRC_CMP_LO = 4'hd;
    localparam logic [3:0] CTU_E2_PIN_HI = 4'h8;
    localparam logic [3:0] CTU_E2_CAP_LO = 4'h9;
    localparam logic [3:0] CTU_E2_CAP_HI = 4'hb;
    localparam logic [3:0] CTU_E2_PCLK = 4'hc;
    // pin n sits at bit n-1 of the pin vector
    localparam logic [3:0] CTU_E1_PIN_OFS = 4'h2;
    localparam logic [3:0] CTU_E2_PIN_OFS = 4'h4;

    localparam logic [2:0] CTU_DS_CCP_LO = 3'h1;
    localparam logic [2:0] CTU_DS_CCP_HI = 3'h3;
    localparam logic [2:0] CTU_DS_EOC = 3'h4;
    localparam logic [2:0] CTU_DS_LOGIC_CELL_ONE_OUTPUT = 3'h6;
    localparam logic [2:0] CTU_DS_CLC2 = 3'h7;

    localparam logic [5:0] CTU_TRIM_UNDEF = 6'h20;
    localparam logic [5:0] CTU_TRIM_MIN = 6'h21;

    typedef enum logic [2:0] {
        CTU_RNG_550NA,
        CTU_RNG_5U5,
        CTU_RNG_55U,
        CTU_RNG_550U,
        CTU_RNG_2M2,
        CTU_RNG_RSVD
    } ctu_range_e;

endpackage

// ### hw/ctu_edge_ctrl.sv
// charge time unit edge control: source select, qualify, status, steering
// assumes pins and comparator outputs are asynchronous; peripherals,
// logic cells and the converter run on core_clk; bus is AHB-Lite
//
// The register offsets and the AHB-Lite slave port were left to the implementer.

`timescale 1ns/1ps

module ctu_edge_ctrl
    import ctu_pkg::*;
#(
    parameter int ADDR_W = CTU_ADDR_W
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic hsel,
    input wire logic [ADDR_W-1:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic idle_mode,
    input wire logic [12:0] edge_input_pin,
    input wire logic [2:0] comparator_out,
    input wire logic timer1_match,
    input wire logic output_compare_one,
    input wire logic [2:0] input_capture_irq,
    input wire logic [2:0] capture_compare_aux,
    input wire logic adc_end_of_conversion,
    input wire logic [1:0] logic_cell_out,
    output logic current_source_on,
    output logic current_grounded,
    output logic route_to_comparator,
    output logic route_to_adc,
    output logic route_to_diode,
    output logic [5:0] current_trim,
    output ctu_range_e current_range,
    output logic current_range_valid,
    output logic trigger_out,
    output logic delay_charge_start
);

    if (ADDR_W < 4) begin : g_addr_chk
        $error("ADDR_W must cover the register map");
    end

    // ************************************************************
    // bus slave
    // ************************************************************
    logic wr_pend_r;
    logic [ADDR_W-1:0] wr_addr_r;
    logic [15:0] timing_r;
    logic [15:0] source_r;
    logic [15:0] disch_r;
    logic seen1_r;
    logic seen2_r;
    logic seen1_nxt;
    logic seen2_nxt;
    logic [31:0] rdata_nxt;
    logic addr_ok;

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    // hsize is not checked: only whole words are expected
    assign addr_ok = hsel && htrans[1] && hready;

    function automatic logic hit(input logic [ADDR_W-1:0] a,
                                 input logic [11:0] ofs);
        hit = (a[ADDR_W-1:2] == (ADDR_W-2)'(ofs >> 2));
    endfunction

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            wr_pend_r <= 1'b0;
            wr_addr_r <= '0;
        end else begin
            wr_pend_r <= addr_ok && hwrite;
            wr_addr_r <= haddr;
        end
    end

    logic wr_timing;
    logic wr_source;
    logic wr_disch;
    assign wr_timing = wr_pend_r && hit(wr_addr_r, CTU_OFS_TIMING);
    assign wr_source = wr_pend_r && hit(wr_addr_r, CTU_OFS_SOURCE);
    assign wr_disch = wr_pend_r && hit(wr_addr_r, CTU_OFS_DISCH);

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            timing_r <= CTU_RST_TIMING;
            source_r <= CTU_RST_SOURCE;
            disch_r <= CTU_RST_DISCH;
        end else begin
            if (wr_timing) begin
                timing_r <= hwdata[15:0] & CTU_MSK_TIMING;
            end
            if (wr_source) begin
                source_r <= hwdata[15:0] & CTU_MSK_SOURCE;
            end
            if (wr_disch) begin
                disch_r <= hwdata[15:0] & CTU_MSK_DISCH;
            end
        end
    end

    // read data registered in the address phase; unmapped reads zero
    always_comb begin
        rdata_nxt = 32'h0000_0000;
        if (hit(haddr, CTU_OFS_TIMING)) begin
            rdata_nxt[15:0] = timing_r;
        end else if (hit(haddr, CTU_OFS_SOURCE)) begin
            rdata_nxt[15:0] = source_r;
            rdata_nxt[CTU_B_SEEN1] = seen1_r;
            rdata_nxt[CTU_B_SEEN2] = seen2_r;
        end else if (hit(haddr, CTU_OFS_DISCH)) begin
            rdata_nxt[15:0] = disch_r;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            hrdata <= 32'h0000_0000;
        end else if (addr_ok && !hwrite) begin
            hrdata <= rdata_nxt;
        end
    end

    // ************************************************************
    // control fields
    // ************************************************************
    logic unit_enable;
    logic stop_in_idle;
    logic delay_generation_enable;
    logic edge_pass_enable;
    logic edge_order_enable;
    logic current_discharge_control;
    logic trigger_output_enable;
    logic high_range_select;
    logic [1:0] range_code;
    logic edge_logic_reset_enable;
    logic [2:0] discharge_source_select;
    logic unit_run;
    logic edge_live;

    assign unit_enable = timing_r[CTU_B_UNIT_EN];
    assign stop_in_idle = timing_r[CTU_B_SIDL];
    assign delay_generation_enable = timing_r[CTU_B_DGEN];
    assign edge_pass_enable = timing_r[CTU_B_EPASS];
    assign edge_order_enable = timing_r[CTU_B_ORDER];
    assign current_discharge_control = timing_r[CTU_B_DISCH];
    assign trigger_output_enable = timing_r[CTU_B_TRIG];
    assign range_code = timing_r[CTU_B_RANGE+:2];
    assign high_range_select = source_r[CTU_B_HIGH_RNG];
    assign edge_logic_reset_enable = disch_r[CTU_B_RST_EN];
    assign discharge_source_select = disch_r[CTU_B_DSRC+:3];

    assign unit_run = unit_enable && !(stop_in_idle && idle_mode);
    assign edge_live = unit_run && edge_pass_enable;

    // ************************************************************
    // synchronisers for pins and comparators
    // ************************************************************
    logic [15:0] async_meta_r;
    logic [15:0] async_sync_r;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            async_meta_r <= 16'h0000;
            async_sync_r <= 16'h0000;
        end else begin
            async_meta_r <= {comparator_out, edge_input_pin};
            async_sync_r <= async_meta_r;
        end
    end

    logic [12:0] pin_s;
    logic [2:0] cmp_s;
    assign pin_s = async_sync_r[12:0];
    assign cmp_s = async_sync_r[15:13];

    // stand-in for the peripheral clock as an edge source
    logic pclk_tgl_r;
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            pclk_tgl_r <= 1'b0;
        end else begin
            pclk_tgl_r <= !pclk_tgl_r;
        end
    end

    // ************************************************************
    // source select
    // ************************************************************
    logic [3:0] e1_code;
    logic [3:0] e2_code;
    logic src1;
    logic src2;
    assign e1_code = source_r[CTU_B_E1_SRC+:4];
    assign e2_code = source_r[CTU_B_E2_SRC+:4];

    always_comb begin
        src1 = 1'b0;
        if (e1_code == CTU_SRC_TIMER1) begin
            src1 = timer1_match;
        end else if (e1_code == CTU_SRC_OC1) begin
            src1 = output_compare_one;
        end else if (e1_code == CTU_SRC_PIN2) begin
            src1 = pin_s[1];
        end else if (e1_code == CTU_SRC_PIN1) begin
            src1 = pin_s[0];
        end else if (e1_code <= CTU_E1_PIN_HI) begin
            src1 = pin_s[4'(e1_code - CTU_E1_PIN_OFS)];
        end else if (e1_code <= CTU_E1_CAP_HI) begin
            src1 = input_capture_irq[2'(e1_code - CTU_E1_CAP_LO)];
        end else begin
            src1 = cmp_s[2'(e1_code - CTU_SRC_CMP_LO)];
        end
    end

    always_comb begin
        src2 = 1'b0;
        if (e2_code == CTU_SRC_TIMER1) begin
            src2 = timer1_match;
        end else if (e2_code == CTU_SRC_OC1) begin
            src2 = output_compare_one;
        end else if (e2_code == CTU_SRC_PIN2) begin
            src2 = pin_s[1];
        end else if (e2_code == CTU_SRC_PIN1) begin
            src2 = pin_s[0];
        end else if (e2_code <= CTU_E2_PIN_HI) begin
            src2 = pin_s[4'(e2_code + CTU_E2_PIN_OFS)];
        end else if (e2_code <= CTU_E2_CAP_HI) begin
            src2 = input_capture_irq[2'(e2_code - CTU_E2_CAP_LO)];
        end else if (e2_code == CTU_E2_PCLK) begin
            src2 = pclk_tgl_r;
        end else begin
            src2 = cmp_s[2'(e2_code - CTU_SRC_CMP_LO)];
        end
    end

    // ************************************************************
    // edge qualification
    // ************************************************************
    // changing a source select can itself look like an edge
    function automatic logic qualify(input logic cur, input logic prev,
                                     input logic sens, input logic pol);
        if (sens) begin
            qualify = pol ? (cur && !prev) : (!cur && prev);
        end else begin
            qualify = pol ? cur : !cur;
        end
    endfunction

    logic src1_prev_r;
    logic src2_prev_r;
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            src1_prev_r <= 1'b0;
            src2_prev_r <= 1'b0;
        end else begin
            src1_prev_r <= src1;
            src2_prev_r <= src2;
        end
    end

    logic ev1_acc;
    logic ev2_acc;
    logic ev_any;
    assign ev1_acc = edge_live && qualify(src1, src1_prev_r,
        source_r[CTU_B_E1_SENS], source_r[CTU_B_E1_POL]);
    assign ev2_acc = edge_live && qualify(src2, src2_prev_r,
        source_r[CTU_B_E2_SENS], source_r[CTU_B_E2_POL])
        && (!edge_order_enable || seen1_r || ev1_acc);
    assign ev_any = ev1_acc || ev2_acc;

    // ************************************************************
    // discharge source and edge status
    // ************************************************************
    logic dsch_sel;
    logic det_rst;
    always_comb begin
        dsch_sel = 1'b0;
        if (discharge_source_select >= CTU_DS_CCP_LO &&
            discharge_source_select <= CTU_DS_CCP_HI) begin
            dsch_sel = capture_compare_aux[
                2'(discharge_source_select - CTU_DS_CCP_LO)];
        end else if (discharge_source_select == CTU_DS_EOC) begin
            dsch_sel = adc_end_of_conversion;
        end else if (discharge_source_select == CTU_DS_LOGIC_CELL_ONE_OUTPUT) begin
            dsch_sel = logic_cell_out[0];
        end else if (discharge_source_select == CTU_DS_CLC2) begin
            dsch_sel = logic_cell_out[1];
        end
    end

    assign det_rst = edge_logic_reset_enable &&
        (dsch_sel || current_discharge_control);

    // detect reset first, then edge set beats the software write
    always_comb begin
        seen1_nxt = seen1_r;
        seen2_nxt = seen2_r;
        if (wr_source) begin
            seen1_nxt = hwdata[CTU_B_SEEN1];
            seen2_nxt = hwdata[CTU_B_SEEN2];
        end
        if (ev1_acc) begin
            seen1_nxt = 1'b1;
        end
        if (ev2_acc) begin
            seen2_nxt = 1'b1;
        end
        if (det_rst) begin
            seen1_nxt = 1'b0;
            seen2_nxt = 1'b0;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            seen1_r <= 1'b0;
            seen2_r <= 1'b0;
        end else begin
            seen1_r <= seen1_nxt;
            seen2_r <= seen2_nxt;
        end
    end

    // ************************************************************
    // event outputs and current steering
    // ************************************************************
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            trigger_out <= 1'b0;
            delay_charge_start <= 1'b0;
        end else begin
            trigger_out <= trigger_output_enable && ev_any;
            delay_charge_start <= delay_generation_enable && ev_any;
        end
    end

    assign current_grounded = current_discharge_control;
    assign current_source_on = unit_run && seen1_r && !seen2_r &&
        !current_discharge_control;
    assign route_to_comparator = delay_generation_enable;
    assign route_to_adc = !delay_generation_enable;
    assign route_to_diode = (seen1_r == seen2_r);

    // 100000 is unlisted, so it saturates at the largest reduction
    logic [5:0] trim_f;
    assign trim_f = timing_r[CTU_B_TRIM+:6];
    assign current_trim = (trim_f == CTU_TRIM_UNDEF) ? CTU_TRIM_MIN
                                                      : trim_f;

    always_comb begin
        current_range_valid = 1'b1;
        unique case ({high_range_select, range_code})
            3'h0: current_range = CTU_RNG_550U;
            3'h1: current_range = CTU_RNG_550NA;
            3'h2: current_range = CTU_RNG_5U5;
            3'h3: current_range = CTU_RNG_55U;
            3'h4: current_range = CTU_RNG_550U;
            3'h5: current_range = CTU_RNG_2M2;
            default: begin
                current_range = CTU_RNG_RSVD;
                current_range_valid = 1'b0;
            end
        endcase
    end

    // ************************************************************
    // assertions
    // ************************************************************
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    sequence s_live_edge;
        delay_generation_enable && ev_any;
    endsequence
    sequence s_clear;
        det_rst;
    endsequence

    chk_disabled_off: assert property (
        !unit_enable |-> !current_source_on)
        else $error("current on while unit disabled");
    chk_idle_halt: assert property (
        (stop_in_idle && idle_mode) |=> !trigger_out && !delay_charge_start)
        else $error("edge event while halted in idle");
    chk_route_mode: assert property (
        route_to_comparator == delay_generation_enable &&
        route_to_adc != route_to_comparator)
        else $error("current routing disagrees with delay mode");
    chk_edges_blocked: assert property (
        (!edge_pass_enable && !wr_source) |=>
        !$rose(seen1_r) && !$rose(seen2_r))
        else $error("status rose with edges blocked");
    chk_edge_order: assert property (
        (edge_order_enable && !seen1_r && !ev1_acc && !wr_source) |=>
        !$rose(seen2_r))
        else $error("edge 2 taken before edge 1");
    chk_ground_off: assert property (
        current_discharge_control |-> current_grounded && !current_source_on)
        else $error("grounded source still on");
    chk_trigger_gate: assert property (
        !trigger_output_enable |=> !trigger_out)
        else $error("trigger without enable");
    chk_trim_code: assert property (
        current_trim != CTU_TRIM_UNDEF)
        else $error("unlisted trim code driven");
    chk_range_high: assert property (
        (high_range_select && range_code[1]) |-> !current_range_valid)
        else $error("reserved high range accepted");
    chk_range_low: assert property (
        (!high_range_select && range_code == 2'h1) |->
        current_range == CTU_RNG_550NA)
        else $error("low range decode wrong");
    chk_diode_route: assert property (
        route_to_diode == (seen1_r == seen2_r))
        else $error("diode route with unequal status");
    chk_delay_start: assert property (
        s_live_edge |=> delay_charge_start)
        else $error("delay charge not started");
    chk_detect_reset: assert property (
        s_clear |=> !seen1_r && !seen2_r)
        else $error("detect reset left status set");
    chk_status_hold: assert property (
        (seen1_r && !det_rst && !wr_source) |=> seen1_r)
        else $error("edge 1 status dropped on its own");
    chk_source_on: assert property (
        (unit_run && seen1_r && !seen2_r && !current_discharge_control)
        |-> current_source_on)
        else $error("current source not on between edges");

endmodule

// ### tb/ctu_src_model.sv
// far-side model: edge pins, comparators, peripherals and converter
// assumes the bench commands pin and converter levels and supplies noise
`timescale 1ns/1ps

module ctu_src_model (
    input wire logic [12:0] pin_cmd,
    input wire logic eoc_cmd,
    input wire logic [12:0] noise,
    output logic [12:0] edge_input_pin,
    output logic [2:0] comparator_out,
    output logic timer1_match,
    output logic output_compare_one,
    output logic [2:0] input_capture_irq,
    output logic [2:0] capture_compare_aux,
    output logic adc_end_of_conversion,
    output logic [1:0] logic_cell_out
);
    assign edge_input_pin = pin_cmd;
    assign adc_end_of_conversion = eoc_cmd;
    // comparator, peripheral and logic cell sources toggle freely so a stray select would show
    assign {comparator_out, timer1_match, output_compare_one,
            input_capture_irq, capture_compare_aux, logic_cell_out} = noise;
endmodule

// ### tb/ctu_edge_ctrl_tb.sv
// bench for the charge time unit edge control
// assumes ctu_pkg, the design and the source model are compiled first
`timescale 1ns/1ps

module ctu_edge_ctrl_tb;
    import ctu_pkg::*;
    // ********
    // signals
    // ********
    logic core_clk = 0, rst = 1, hsel = 0, hwrite = 0, idle_mode = 0;
    logic eoc_cmd = 0, hreadyout, hresp, current_source_on;
    logic current_grounded, route_to_comparator, route_to_adc;
    logic route_to_diode, trigger_out, delay_charge_start;
    logic current_range_valid, timer1_match, output_compare_one;
    logic adc_end_of_conversion;
    logic [11:0] haddr = 0;
    logic [1:0] htrans = 0, logic_cell_out;
    logic [31:0] hwdata = 0, hrdata, q, lf = 32'h356f3443;
    logic [15:0] t, s;
    logic [12:0] pin_cmd = 13'h0100, noise = 0, edge_input_pin;
    logic [2:0] comparator_out, input_capture_irq, capture_compare_aux;
    logic [5:0] current_trim;
    ctu_range_e current_range;
    logic [15:0] tim [5] = '{16'h8800, 16'h0800, 16'h8000, 16'ha800, 16'h8800};
    logic [4:0] idl = 5'b11000, sn = 5'b10001;
    int n_errors = 0, check_count = 0, n_trig = 0, n_dly = 0;

    ctu_edge_ctrl dut_u (
        .core_clk, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
        .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .idle_mode,
        .edge_input_pin, .comparator_out, .timer1_match, .output_compare_one,
        .input_capture_irq, .capture_compare_aux, .adc_end_of_conversion,
        .logic_cell_out, .current_source_on, .current_grounded,
        .route_to_comparator, .route_to_adc, .route_to_diode, .current_trim,
        .current_range, .current_range_valid, .trigger_out,
        .delay_charge_start);
    ctu_src_model src_u (
        .pin_cmd, .eoc_cmd, .noise, .edge_input_pin, .comparator_out,
        .timer1_match, .output_compare_one, .input_capture_irq,
        .capture_compare_aux, .adc_end_of_conversion, .logic_cell_out);

    // ********
    // helpers
    // ********
    function automatic logic [31:0] lfsr(logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    function automatic ctu_range_e exp_rng(logic [2:0] c);
        case (c)
            3'b001: return CTU_RNG_550NA;
            3'b010: return CTU_RNG_5U5;
            3'b011: return CTU_RNG_55U;
            3'b101: return CTU_RNG_2M2;
            default: return CTU_RNG_550U;
        endcase
    endfunction
    task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
        check_count++;
        if (g !== e) begin
            n_errors++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask
    // zero wait states expected, but the wait is left open for the watchdog
    task automatic xfer(logic w, logic [11:0] a, logic [31:0] d);
        @(posedge core_clk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= a;
        hwrite <= w;
        do @(posedge core_clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge core_clk); while (hreadyout !== 1'b1);
        q = hrdata;
        chk("hresp", 0, hresp);
    endtask
    task automatic rd(logic [11:0] a, logic [31:0] e, string nm);
        xfer(1'b0, a, 0);
        chk(nm, e, q);
    endtask
    task automatic cyc(int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    // pins pass a two-flop sync; eight cycles is ample
    task automatic step(logic [12:0] p, logic [15:0] e);
        pin_cmd <= p;
        cyc(8);
        rd(CTU_OFS_SOURCE, e, "status");
    endtask
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // ********
    // stimulus
    // ********
    initial forever #2.5 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        lf <= lfsr(lf);
        noise <= lf[12:0];
    end
    always @(negedge core_clk) begin
        if (trigger_out === 1'b1) n_trig++;
        if (delay_charge_start === 1'b1) n_dly++;
    end
    // whole run is a few hundred cycles; this is far beyond it
    initial begin
        #100000;
        n_errors++;
        print_verdict;
    end
    initial begin
        repeat (8) @(posedge core_clk);
        rst <= 1'b0;
        rd(CTU_OFS_TIMING, CTU_RST_TIMING, "timing");
        rd(CTU_OFS_SOURCE, CTU_RST_SOURCE, "source");
        rd(CTU_OFS_DISCH, CTU_RST_DISCH, "disch");
        rd(12'h00c, 0, "unmapped");
        $display("test reset done");
        for (int i = 0; i < 8; i++) begin
            t = (lf[15:0] & 16'h7ffc) | i[1:0];
            s = (lf[31:16] & 16'hfffe) | i[2];
            if (i == 0) t[7:2] = CTU_TRIM_UNDEF;
            xfer(1, CTU_OFS_DISCH, {29'h0, lf[2:0]});
            xfer(1, CTU_OFS_TIMING, {16'h0, t});
            xfer(1, CTU_OFS_SOURCE, {16'h0, s});
            rd(CTU_OFS_TIMING, t & CTU_MSK_TIMING, "timing");
            rd(CTU_OFS_SOURCE, s & CTU_MSK_SOURCE, "source");
            chk("valid", !(i[2] & i[1]), current_range_valid);
            if (!(i[2] & i[1]))
                chk("range", exp_rng(i[2:0]), current_range);
            chk("trim", t[7:2] == CTU_TRIM_UNDEF ? CTU_TRIM_MIN : t[7:2],
                current_trim);
            chk("ground", t[9], current_grounded);
            chk("cmp", t[12], route_to_comparator);
            chk("adc", !t[12], route_to_adc);
            chk("diode", s[9] == s[8], route_to_diode);
            chk("on", 0, current_source_on);
        end
        $display("test registers done");
        for (int k = 0; k < 5; k++) begin
            idle_mode <= idl[k];
            // status cleared first: live edges on old sources would win
            xfer(1, CTU_OFS_SOURCE, 32'hcc90);
            xfer(1, CTU_OFS_TIMING, {16'h0, tim[k]});
            step(13'h0101, {7'h66, sn[k], 8'h90});
            chk("on", sn[k], current_source_on);
            pin_cmd <= 13'h0100;
        end
        idle_mode <= 1'b0;
        xfer(1, CTU_OFS_SOURCE, 32'hcc90);
        step(13'h0000, 16'hce90);
        xfer(1, CTU_OFS_TIMING, 32'h8c00);
        step(13'h0100, 16'hce90);
        xfer(1, CTU_OFS_SOURCE, 32'hcc90);
        step(13'h0000, 16'hcc90);
        step(13'h0001, 16'hcd90);
        chk("diode", 0, route_to_diode);
        step(13'h0101, 16'hcd90);
        step(13'h0001, 16'hcf90);
        chk("on", 0, current_source_on);
        $display("test edges done");
        xfer(1, CTU_OFS_DISCH, 32'h0010);
        rd(CTU_OFS_SOURCE, 16'hcf90, "status");
        xfer(1, CTU_OFS_TIMING, 32'h8e00);
        rd(CTU_OFS_SOURCE, 16'hcc90, "status");
        chk("ground", 1, current_grounded);
        xfer(1, CTU_OFS_TIMING, 32'h8c00);
        xfer(1, CTU_OFS_DISCH, 32'h0014);
        xfer(1, CTU_OFS_SOURCE, 32'hcd90);
        rd(CTU_OFS_SOURCE, 16'hcd90, "status");
        @(posedge core_clk);
        eoc_cmd <= 1'b1;
        @(posedge core_clk);
        eoc_cmd <= 1'b0;
        rd(CTU_OFS_SOURCE, 16'hcc90, "status");
        xfer(1, CTU_OFS_DISCH, 32'h0000);
        $display("test discharge done");
        for (int j = 0; j < 2; j++) begin
            xfer(1, CTU_OFS_TIMING, j ? 32'h9900 : 32'h8800);
            xfer(1, CTU_OFS_SOURCE, 32'hcc90);
            step(13'h0000, 16'hcc90);
            n_trig = 0;
            n_dly = 0;
            step(13'h0001, 16'hcd90);
            chk("trig", j, n_trig);
            chk("delay", j, n_dly);
            chk("cmp", j, route_to_comparator);
        end
        $display("test pulses done");
        print_verdict;
    end
endmodule
